// File: rtl/sscw_top.sv
// sscw_top: serial control word decode, protection and AXI4-Lite status block
// assumes: pins are asynchronous to aclk; an AXI4-Lite master on aclk
`timescale 1ns/10ps
`default_nettype none
module sscw_top
  import sscw_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 2
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              serial_clock_pair_one,
  input  wire logic              serial_in_pair_one,
  input  wire logic              latch_pulse_pair_one,
  input  wire logic              motor_reset_n,
  input  wire logic              logic_supply_ok,
  input  wire logic              motor_supply_ok,
  input  wire logic              thermal_shutdown,
  input  wire logic              overcurrent_shutdown,
  output logic                   phase_a_true,
  output logic                   phase_a_comp,
  output logic                   phase_b_true,
  output logic                   phase_b_comp,
  output logic [3:0]             phase_a_current,
  output logic [3:0]             phase_b_current,
  output logic [3:0]             phase_a_decay,
  output logic [3:0]             phase_b_decay,
  output logic [6:0]             torque_pct_out,
  output logic                   charge_pump_run
);
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  sscw_word_if lk ();

  logic [NPIN-1:0] sync_q [SYNC_STAGES];
  logic [NPIN-1:0] pins_s;
  logic            rst_pin_q;
  logic            therm_q;
  logic            oc_q;
  logic            uv_logic;
  logic            uv_motor;
  logic            rst_pin_low;
  logic            rst_rise;
  logic            clr;
  logic            hold;
  logic            off;
  logic [15:0]     word;
  logic [15:0]     dtab_q;

  // pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < SYNC_STAGES; i++) sync_q[i] <= PIN_RST;
    end else begin
      sync_q[0] <= {overcurrent_shutdown, thermal_shutdown, motor_supply_ok,
                    logic_supply_ok, motor_reset_n, latch_pulse_pair_one,
                    serial_in_pair_one, serial_clock_pair_one};
      for (int i = 1; i < SYNC_STAGES; i++) sync_q[i] <= sync_q[i-1];
    end
  end
  assign pins_s = sync_q[SYNC_STAGES-1];

  assign uv_logic    = ~pins_s[PIN_LSOK];
  assign uv_motor    = ~pins_s[PIN_MSOK];
  assign rst_pin_low = ~pins_s[PIN_RSTN];
  assign rst_rise    = ~rst_pin_q & pins_s[PIN_RSTN];
  assign clr         = rst_pin_low | uv_logic | uv_motor;
  assign hold        = therm_q | oc_q;
  assign off         = clr | hold;
  assign word        = lk.latched_word;

  assign lk.sclk = pins_s[PIN_SCLK];
  assign lk.sdat = pins_s[PIN_SDAT];
  assign lk.stb  = pins_s[PIN_STB];
  assign lk.clr  = clr;
  assign lk.hold = hold;

  sscw_shift u_shift (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lk      (lk.shifter)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) rst_pin_q <= 1'b0;
    else rst_pin_q <= pins_s[PIN_RSTN];
  end

  // thermal fault held until reset pin rises
  always_ff @(posedge aclk) begin
    if (!aresetn) therm_q <= 1'b0;
    else if (pins_s[PIN_TSD]) therm_q <= 1'b1;
    else if (rst_rise) therm_q <= 1'b0;
  end

  // overcurrent trip held until reset pin is low
  always_ff @(posedge aclk) begin
    if (!aresetn) oc_q <= 1'b0;
    else if (pins_s[PIN_OCS]) oc_q <= 1'b1;
    else if (rst_pin_low) oc_q <= 1'b0;
  end

  // AXI4-Lite write side
  logic              aw_ok_q;
  logic              w_ok_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_fire;
  logic              wr_hit;

  assign wr_fire = aw_ok_q && w_ok_q && !s_axi_bvalid;
  assign wr_hit  = (aw_addr_q == A_LATCH) || (aw_addr_q == A_SHIFT) ||
                   (aw_addr_q == A_STAT) || (aw_addr_q == A_DTAB);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_q       <= 1'b0;
      aw_addr_q     <= '0;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_q       <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_ok_q <= 1'b0;
    end else if (!aw_ok_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_ok_q       <= 1'b0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_ok_q       <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_ok_q <= 1'b0;
    end else if (!w_ok_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DEC;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // decay table, software writable while running
  always_ff @(posedge aclk) begin
    if (!aresetn || uv_logic) begin
      dtab_q <= DTAB_RST;
    end else if (wr_fire && aw_addr_q == A_DTAB && !off) begin
      if (w_strb_q[0]) dtab_q[7:0] <= w_data_q[7:0];
      if (w_strb_q[1]) dtab_q[15:8] <= w_data_q[15:8];
    end
  end

  // AXI4-Lite read side
  logic [31:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (s_axi_araddr)
      A_LATCH: rd_word[15:0] = word;
      A_SHIFT: rd_word[15:0] = lk.shift_word;
      A_STAT: begin
        rd_word[ST_UVL]    = uv_logic;
        rd_word[ST_UVM]    = uv_motor;
        rd_word[ST_THERM]  = therm_q;
        rd_word[ST_OC]     = oc_q;
        rd_word[ST_PUMP]   = charge_pump_run;
        rd_word[ST_RSTPIN] = pins_s[PIN_RSTN];
      end
      A_DTAB:  rd_word[15:0] = dtab_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DEC;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // charge pump enable
  always_ff @(posedge aclk) begin
    if (!aresetn) charge_pump_run <= 1'b0;
    else charge_pump_run <= ~off;
  end

  // word decode to phase drive
  logic [3:0] cur_a;
  logic [3:0] cur_b;
  assign cur_a = word[CURA_LSB +: 4];
  assign cur_b = word[CURB_LSB +: 4];

  always_ff @(posedge aclk) begin
    if (!aresetn || off) begin
      phase_a_true    <= 1'b0;
      phase_a_comp    <= 1'b0;
      phase_b_true    <= 1'b0;
      phase_b_comp    <= 1'b0;
      phase_a_current <= CUR_OFF;
      phase_b_current <= CUR_OFF;
      phase_a_decay   <= '0;
      phase_b_decay   <= '0;
      torque_pct_out  <= '0;
    end else begin
      phase_a_current <= cur_a;
      phase_b_current <= cur_b;
      phase_a_decay   <= decay_entry(dtab_q, word[DCYA_LSB +: 2]);
      phase_b_decay   <= decay_entry(dtab_q, word[DCYB_LSB +: 2]);
      torque_pct_out  <= torque_pct(word[TRQ_LSB +: 2]);
      phase_a_true    <= (cur_a != CUR_OFF) && word[PHA_BIT];
      phase_a_comp    <= (cur_a != CUR_OFF) && !word[PHA_BIT];
      phase_b_true    <= (cur_b != CUR_OFF) && word[PHB_BIT];
      phase_b_comp    <= (cur_b != CUR_OFF) && !word[PHB_BIT];
    end
  end

  a_pump_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    off |=> !charge_pump_run) else $error("charge pump ran during reset or fault");
  a_outputs_off: assert property (@(posedge aclk) disable iff (!aresetn)
    off |=> !phase_a_true && !phase_a_comp && !phase_b_true && !phase_b_comp)
    else $error("outputs driven during reset or fault");
  a_zero_current: assert property (@(posedge aclk) disable iff (!aresetn)
    (!off && cur_b == CUR_OFF) |=> !phase_b_true && !phase_b_comp)
    else $error("zero current phase not off");
  a_phase_pol: assert property (@(posedge aclk) disable iff (!aresetn)
    (!off && cur_a != CUR_OFF) |=> (phase_a_true == $past(word[PHA_BIT]))
                                    && (phase_a_comp == !$past(word[PHA_BIT])))
    else $error("phase polarity wrong");
  a_torque_map: assert property (@(posedge aclk) disable iff (!aresetn)
    (!off && word[1:0] == 2'h2) |=> torque_pct_out == PCT_85)
    else $error("torque ratio wrong");
  a_decay_pick: assert property (@(posedge aclk) disable iff (!aresetn)
    (!off && word[DCYB_LSB +: 2] == 2'h1 && dtab_q == DTAB_RST) |=> phase_b_decay == 4'hA)
    else $error("decay entry wrong");
  a_oc_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (oc_q && !rst_pin_low) |=> oc_q) else $error("overcurrent trip released early");
  a_fault_or: assert property (@(posedge aclk) disable iff (!aresetn)
    (pins_s[PIN_TSD] || pins_s[PIN_OCS]) |=> hold ##1 !charge_pump_run)
    else $error("single fault did not stop block");
  a_table_uv: assert property (@(posedge aclk) disable iff (!aresetn)
    uv_logic |=> dtab_q == DTAB_RST) else $error("table not restored on undervoltage");
  a_sync_lag: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pins_s[PIN_TSD]) |-> $past(sync_q[0][PIN_TSD], 1))
    else $error("fault pin skipped synchroniser");
  c_run: cover property (@(posedge aclk) disable iff (!aresetn) phase_a_true && phase_b_comp);
  c_oc_trip: cover property (@(posedge aclk) disable iff (!aresetn) $rose(oc_q));
  c_tab_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && aw_addr_q == A_DTAB);
endmodule : sscw_top
`default_nettype wire

// File: include/sscw_pkg.sv
// sscw_pkg: constants, field layout and helpers of the serial control word block
// assumes: compiled before every other file of the block
package sscw_pkg;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned TRQ_LSB  = 0;
  localparam int unsigned DCYB_LSB = 2;
  localparam int unsigned CURB_LSB = 4;
  localparam int unsigned PHB_BIT  = 8;
  localparam int unsigned DCYA_LSB = 9;
  localparam int unsigned CURA_LSB = 11;
  localparam int unsigned PHA_BIT  = 15;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] DTAB_RST = 16'hFDA0;
  localparam logic [3:0]  CUR_OFF  = 4'h0;
  localparam logic [6:0]  PCT_100  = 7'h64;
  localparam logic [6:0]  PCT_85   = 7'h55;
  localparam logic [6:0]  PCT_70   = 7'h46;
  localparam logic [6:0]  PCT_50   = 7'h32;
  localparam int unsigned NPIN      = 8;
  localparam int unsigned PIN_SCLK  = 0;
  localparam int unsigned PIN_SDAT  = 1;
  localparam int unsigned PIN_STB   = 2;
  localparam int unsigned PIN_RSTN  = 3;
  localparam int unsigned PIN_LSOK  = 4;
  localparam int unsigned PIN_MSOK  = 5;
  localparam int unsigned PIN_TSD   = 6;
  localparam int unsigned PIN_OCS   = 7;
  localparam logic [7:0]  PIN_RST   = 8'h00;
  localparam int unsigned ADDR_W    = 4;
  localparam logic [3:0]  A_LATCH   = 4'h0;
  localparam logic [3:0]  A_SHIFT   = 4'h4;
  localparam logic [3:0]  A_STAT    = 4'h8;
  localparam logic [3:0]  A_DTAB    = 4'hC;
  localparam int unsigned ST_UVL    = 0;
  localparam int unsigned ST_UVM    = 1;
  localparam int unsigned ST_THERM  = 2;
  localparam int unsigned ST_OC     = 3;
  localparam int unsigned ST_PUMP   = 4;
  localparam int unsigned ST_RSTPIN = 5;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_DEC  = 2'h3;

  function automatic logic [6:0] torque_pct(input logic [1:0] t);
    unique case (t)
      2'h3:    torque_pct = PCT_100;
      2'h2:    torque_pct = PCT_85;
      2'h1:    torque_pct = PCT_70;
      default: torque_pct = PCT_50;
    endcase
  endfunction : torque_pct

  function automatic logic [3:0] decay_entry(input logic [15:0] tab, input logic [1:0] sel);
    decay_entry = tab[{sel, 2'h0} +: 4];
  endfunction : decay_entry
endpackage : sscw_pkg

// File: include/sscw_word_if.sv
// sscw_word_if: synchronised serial pins and word state between top and shifter
// assumes: all signals live in the aclk domain
`timescale 1ns/10ps
`default_nettype none
interface sscw_word_if;
  logic        sclk;
  logic        sdat;
  logic        stb;
  logic        clr;
  logic        hold;
  logic [15:0] shift_word;
  logic [15:0] latched_word;
  logic        latch_evt;
  modport shifter (input sclk, sdat, stb, clr, hold,
                   output shift_word, latched_word, latch_evt);
  modport ctrl (output sclk, sdat, stb, clr, hold,
                input shift_word, latched_word, latch_evt);
endinterface : sscw_word_if
`default_nettype wire

// File: rtl/sscw_shift.sv
// sscw_shift: serial shift register and output latch of the control word
// assumes: pin levels on the interface are already synchronised to aclk
`timescale 1ns/10ps
`default_nettype none
module sscw_shift
  import sscw_pkg::*;
(
  input wire logic    aclk,
  input wire logic    aresetn,
  sscw_word_if.shifter lk
);
  logic        sclk_q;
  logic        stb_q;
  logic        dbit_q;
  logic        evt_q;
  logic [15:0] sh_q;
  logic [15:0] lat_q;
  logic        fall;
  logic        rise;
  logic        stb_rise;

  assign fall     = sclk_q & ~lk.sclk;
  assign rise     = ~sclk_q & lk.sclk;
  assign stb_rise = ~stb_q & lk.stb;
  assign lk.shift_word   = sh_q;
  assign lk.latched_word = lat_q;
  assign lk.latch_evt    = evt_q;

  // edge trackers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_q <= 1'b0;
      stb_q  <= 1'b0;
    end else begin
      sclk_q <= lk.sclk;
      stb_q  <= lk.stb;
    end
  end

  // data captured on falling clock
  always_ff @(posedge aclk) begin
    if (!aresetn) dbit_q <= 1'b0;
    else if (fall) dbit_q <= lk.sdat;
  end

  // shift right so the first bit ends in bit 0
  always_ff @(posedge aclk) begin
    if (!aresetn || lk.clr) sh_q <= WORD_RST;
    else if (rise && !lk.hold) sh_q <= {dbit_q, sh_q[15:1]};
  end

  // output latch
  always_ff @(posedge aclk) begin
    if (!aresetn || lk.clr) begin
      lat_q <= WORD_RST;
      evt_q <= 1'b0;
    end else begin
      evt_q <= stb_rise && !lk.hold;
      if (stb_rise && !lk.hold) lat_q <= sh_q;
    end
  end

  a_shift_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!rise && !lk.clr) |=> $stable(sh_q)) else $error("shift register moved without clock");
  a_shift_order: assert property (@(posedge aclk) disable iff (!aresetn)
    (rise && !lk.hold && !lk.clr) |=> (sh_q == {$past(dbit_q), $past(sh_q[15:1])}))
    else $error("shift order wrong");
  a_latch_take: assert property (@(posedge aclk) disable iff (!aresetn)
    (stb_rise && !lk.hold && !lk.clr) |=> (lat_q == $past(sh_q)) && evt_q)
    else $error("strobe did not latch word");
  a_latch_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    (!stb_rise && !lk.clr) |=> $stable(lat_q)) else $error("latch changed without strobe");
  a_clear_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    lk.clr |=> (sh_q == WORD_RST)) else $error("shift register not cleared");
  c_latch: cover property (@(posedge aclk) disable iff (!aresetn) evt_q);
endmodule : sscw_shift
`default_nettype wire

// File: dv/sscw_host_model.sv
// sscw_host_model: host side of the serial link, shifts words and strobes
// assumes: tasks are called just after an aclk rising edge
`timescale 1ns/10ps
`default_nettype none
module sscw_host_model (
  input  wire logic aclk,
  output var logic  sclk,
  output var logic  sdat,
  output var logic  stb
);
  initial begin
    sclk = 1'b1;
    sdat = 1'b0;
    stb  = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask : hold

  // half period of 8 aclk gives the 160 ns link clock, idle high
  task automatic send_word(input logic [15:0] w, input logic latch);
    for (int i = 0; i < 16; i++) begin
      sdat <= w[i];
      hold(4);
      sclk <= 1'b0;
      hold(8);
      sclk <= 1'b1;
      hold(4);
    end
    sdat <= ~w[15];
    if (latch) begin
      stb <= 1'b1;
      hold(8);
      stb <= 1'b0;
    end
    hold(8);
  endtask : send_word

  // data moves with the serial clock standing still
  task automatic wiggle();
    repeat (4) begin
      sdat <= ~sdat;
      hold(4);
    end
  endtask : wiggle
endmodule : sscw_host_model
`default_nettype wire

// File: dv/sscw_top_tb.sv
// sscw_top_tb: self-checking bench of the serial control word block
// assumes: package, word interface and design files compiled first
`timescale 1ns/10ps
`default_nettype none
module sscw_top_tb
  import sscw_pkg::*;
;
  logic        aclk, aresetn, charge_pump_run;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, serial_clock_pair_one;
  logic        serial_in_pair_one, latch_pulse_pair_one, motor_reset_n;
  logic        logic_supply_ok, motor_supply_ok, thermal_shutdown;
  logic        overcurrent_shutdown, phase_a_true, phase_a_comp;
  logic        phase_b_true, phase_b_comp;
  logic [3:0]  phase_a_current, phase_b_current, phase_a_decay, phase_b_decay;
  logic [6:0]  torque_pct_out;
  int          errors, samples_checked;
  wire logic [31:0] outs = {5'h0, torque_pct_out, phase_a_true, phase_a_comp,
    phase_b_true, phase_b_comp, phase_a_current, phase_b_current, phase_a_decay,
    phase_b_decay};

  sscw_top i_sscw_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock_pair_one,
    .serial_in_pair_one, .latch_pulse_pair_one, .motor_reset_n, .logic_supply_ok,
    .motor_supply_ok, .thermal_shutdown, .overcurrent_shutdown, .phase_a_true,
    .phase_a_comp, .phase_b_true, .phase_b_comp, .phase_a_current, .phase_b_current,
    .phase_a_decay, .phase_b_decay, .torque_pct_out, .charge_pump_run);
  sscw_host_model i_sscw_host_model (.aclk, .sclk(serial_clock_pair_one),
    .sdat(serial_in_pair_one), .stb(latch_pulse_pair_one));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [9:0] ph(logic [3:0] c, logic [1:0] s, logic p, logic [15:0] t);
    if (c == 4'h0) return {6'h00, t[4*s +: 4]};
    return {p, ~p, c, t[4*s +: 4]};
  endfunction : ph

  function automatic logic [31:0] exp_out(logic [15:0] w, logic [15:0] t);
    logic [9:0] a;
    logic [9:0] b;
    logic [6:0] p;
    a = ph(w[14:11], w[10:9], w[15], t);
    b = ph(w[7:4], w[3:2], w[8], t);
    case ({w[0], w[1]})
      2'b11: p = PCT_100;
      2'b01: p = PCT_85;
      2'b10: p = PCT_70;
      default: p = PCT_50;
    endcase
    return {5'h0, p, a[9:8], b[9:8], a[7:4], b[7:4], a[3:0], b[3:0]};
  endfunction : exp_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    if (er == RESP_OKAY) check(s_axi_rdata, e);
    check({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : rd

  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask : settle

  task automatic t_reset();
    check(outs, 32'h0);
    check({31'h0, charge_pump_run}, 32'h0);
    rd(A_DTAB, 32'hFDA0, RESP_OKAY);
    rd(4'h2, 32'h0, RESP_DEC);
    wr(A_LATCH, 32'h5555, RESP_OKAY);
    rd(A_LATCH, 32'h0, RESP_OKAY);
    motor_reset_n <= 1'b1;
    settle();
    rd(A_STAT, 32'h30, RESP_OKAY);
  endtask : t_reset

  task automatic t_decode();
    logic [15:0] ws [4] = '{16'h0013, 16'h8A56, 16'h7D29, 16'hE60C};
    foreach (ws[i]) begin
      i_sscw_host_model.send_word(ws[i], 1'b1);
      check(outs, exp_out(ws[i], 16'hFDA0));
      rd(A_LATCH, {16'h0, ws[i]}, RESP_OKAY);
      rd(A_SHIFT, {16'h0, ws[i]}, RESP_OKAY);
    end
    i_sscw_host_model.send_word(16'h0013, 1'b0);
    i_sscw_host_model.wiggle();
    rd(A_SHIFT, 32'h0013, RESP_OKAY);
    check(outs, exp_out(16'hE60C, 16'hFDA0));
    wr(A_DTAB, 32'h1234, RESP_OKAY);
    rd(A_DTAB, 32'h1234, RESP_OKAY);
    i_sscw_host_model.send_word(16'h7D29, 1'b1);
    check(outs, exp_out(16'h7D29, 16'h1234));
  endtask : t_decode

  task automatic t_supply();
    motor_supply_ok <= 1'b0;
    settle();
    check(outs, 32'h0);
    check({31'h0, charge_pump_run}, 32'h0);
    rd(A_SHIFT, 32'h0, RESP_OKAY);
    rd(A_DTAB, 32'h1234, RESP_OKAY);
    motor_supply_ok <= 1'b1;
    logic_supply_ok <= 1'b0;
    settle();
    rd(A_DTAB, 32'hFDA0, RESP_OKAY);
    rd(A_STAT, 32'h21, RESP_OKAY);
    logic_supply_ok <= 1'b1;
    settle();
  endtask : t_supply

  task automatic t_fault();
    i_sscw_host_model.send_word(16'h8A56, 1'b1);
    thermal_shutdown <= 1'b1;
    settle();
    check(outs, 32'h0);
    check({31'h0, charge_pump_run}, 32'h0);
    i_sscw_host_model.send_word(16'h0013, 1'b1);
    rd(A_SHIFT, 32'h8A56, RESP_OKAY);
    thermal_shutdown <= 1'b0;
    settle();
    check({31'h0, charge_pump_run}, 32'h0);
    motor_reset_n <= 1'b0;
    settle();
    motor_reset_n <= 1'b1;
    settle();
    check({31'h0, charge_pump_run}, 32'h1);
    i_sscw_host_model.send_word(16'h8A56, 1'b1);
    check(outs, exp_out(16'h8A56, 16'hFDA0));
    overcurrent_shutdown <= 1'b1;
    settle();
    overcurrent_shutdown <= 1'b0;
    settle();
    check(outs, 32'h0);
    rd(A_STAT, 32'h28, RESP_OKAY);
    motor_reset_n <= 1'b0;
    settle();
    rd(A_SHIFT, 32'h0, RESP_OKAY);
    motor_reset_n <= 1'b1;
    settle();
    check({31'h0, charge_pump_run}, 32'h1);
  endtask : t_fault

  initial begin
    errors = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {motor_reset_n, thermal_shutdown, overcurrent_shutdown} = '0;
    {logic_supply_ok, motor_supply_ok} = 2'h3;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    t_reset();
    t_decode();
    t_supply();
    t_fault();
    conclude();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    conclude();
  end
endmodule : sscw_top_tb
`default_nettype wire
